/* File: hdl/tmc_conversion_control.sv */
// conversion sequencer, control registers and alarm pin of the temperature monitor
`timescale 1ns/1ps
module tmc_conversion_control #(
  parameter logic [tmc_pkg::CNT_W-1:0] REMOTE_CYCLES         = tmc_pkg::REMOTE_CYCLES_DFLT,
  parameter logic [tmc_pkg::CNT_W-1:0] LOCAL_9BIT_CYCLES     = tmc_pkg::LOCAL_9BIT_CYCLES_DFLT,
  parameter logic [tmc_pkg::CNT_W-1:0] SLOWEST_PERIOD_CYCLES = tmc_pkg::SLOWEST_PERIOD_CYCLES_DFLT
) (
  // clock and reset
  input  wire logic           ref_clk,
  input  wire logic           rst,
  // pointer register port from the serial front end
  input  tmc_pkg::tmc_wr_s    regWr,
  input  tmc_pkg::tmc_rd_s    regRd,
  output logic [7:0]          rdData,
  output logic                rdValid,
  // limit comparator results and alert response
  input  wire logic           localOutOfLimit,
  input  wire logic           remoteOutOfLimit,
  input  wire logic           alarmClear,
  // converter control
  output logic                busy,
  output logic                remoteActive,
  output logic                localActive,
  output logic                remoteSampled,
  output logic                localSampled,
  output logic [1:0]          localPrecision,
  output logic [7:0]          idealityApplied,
  output logic                wireResistanceFix,
  // open-drain alarm pin
  output logic                alertPinOut,
  output logic                alertPinOeN,
  output logic                alarmState
);
  import tmc_pkg::*;

  // control register state
  logic       cfgMask;
  logic       cfgHalt;
  logic [7:0] rateCode;
  logic [7:0] ideality;
  logic [7:0] precision;
  logic       wireFix;
  logic [2:0] consecCode;
  logic       oneShotReq;
  logic       next_cfgMask;
  logic       next_cfgHalt;
  logic [7:0] next_rateCode;
  logic [7:0] next_ideality;
  logic [7:0] next_precision;
  logic       next_wireFix;
  logic [2:0] next_consecCode;
  logic       next_oneShotReq;

  // read path state
  logic [7:0] next_rdData;
  logic       next_rdValid;

  // sequencer state
  tmc_state_e       state;
  tmc_state_e       next_state;
  logic [CNT_W-1:0] phaseCnt;
  logic [CNT_W-1:0] periodCnt;
  logic [CNT_W-1:0] next_phaseCnt;
  logic [CNT_W-1:0] next_periodCnt;
  logic             oneShotActive;
  logic             next_oneShotActive;
  logic             next_busy;
  logic             next_remoteActive;
  logic             next_localActive;
  logic             next_remoteSampled;
  logic             next_localSampled;
  logic [7:0]       next_idealityApplied;

  // derived timing
  logic [2:0]       rateSel;
  logic [CNT_W-1:0] periodCycles;
  logic [CNT_W-1:0] localCycles;
  logic             runAllowed;

  // alarm state
  logic [1:0] chanSample;
  logic [1:0] chanOut;
  logic [1:0] chanTrip;
  logic [2:0] consecNeed;
  logic       next_alarmState;
  logic       next_alertPinOeN;

  // register writes; reserved config, wire fix and consecutive bits are dropped so they read zero, precision keeps all eight bits
  always_comb begin
    next_cfgMask    = cfgMask;
    next_cfgHalt    = cfgHalt;
    next_rateCode   = rateCode;
    next_ideality   = ideality;
    next_precision  = precision;
    next_wireFix    = wireFix;
    next_consecCode = consecCode;
    next_oneShotReq = 1'b0;
    if (regWr.en) begin
      case (regWr.ptr)
        PTR_CONFIG_WR: begin
          next_cfgMask = regWr.data[CFG_MASK_BIT];
          next_cfgHalt = regWr.data[CFG_HALT_BIT];
        end
        PTR_RATE_WR: begin
          next_rateCode = regWr.data;
        end
        PTR_IDEALITY: begin
          next_ideality = regWr.data;
        end
        PTR_PRECISION: begin
          next_precision = regWr.data;
        end
        PTR_WIREFIX: begin
          next_wireFix = regWr.data[WIREFIX_BIT];
        end
        PTR_CONSEC: begin
          next_consecCode = regWr.data[CONSEC_LSB +: 3];
        end
        PTR_ONESHOT: begin
          next_oneShotReq = regWr.data[ONESHOT_BIT];
        end
        default: begin
          next_oneShotReq = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfgMask    <= CONFIG_RST[CFG_MASK_BIT];
      cfgHalt    <= CONFIG_RST[CFG_HALT_BIT];
      rateCode   <= RATE_RST;
      ideality   <= IDEALITY_RST;
      precision  <= PRECISION_RST;
      wireFix    <= WIREFIX_RST[WIREFIX_BIT];
      consecCode <= CONSEC_RST[2:0];
      oneShotReq <= 1'b0;
    end else begin
      cfgMask    <= next_cfgMask;
      cfgHalt    <= next_cfgHalt;
      rateCode   <= next_rateCode;
      ideality   <= next_ideality;
      precision  <= next_precision;
      wireFix    <= next_wireFix;
      consecCode <= next_consecCode;
      oneShotReq <= next_oneShotReq;
    end
  end

  // register reads; write-only and unknown pointers answer zero
  always_comb begin
    next_rdValid = regRd.en;
    next_rdData  = rdData;
    if (regRd.en) begin
      case (regRd.ptr)
        PTR_CONFIG_RD: next_rdData = {cfgMask, cfgHalt, 6'h00};
        PTR_RATE_RD:   next_rdData = rateCode;
        PTR_IDEALITY:  next_rdData = ideality;
        PTR_PRECISION: next_rdData = precision;
        PTR_WIREFIX:   next_rdData = {7'h00, wireFix};
        PTR_CONSEC:    next_rdData = {5'h00, consecCode};
        default:       next_rdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdData  <= 8'h00;
      rdValid <= 1'b0;
    end else begin
      rdData  <= next_rdData;
      rdValid <= next_rdValid;
    end
  end

  // timing from the settings; the period is measured start to start, so the
  // rate sets only the idle gap while the precision stretches the busy part
  assign rateSel      = (rateCode >= RATE_FASTEST) ? 3'h7 : rateCode[2:0];
  assign periodCycles = SLOWEST_PERIOD_CYCLES >> rateSel;
  assign localCycles  = LOCAL_9BIT_CYCLES << {precision[PREC_HI_BIT], precision[PREC_LO_BIT]};
  assign runAllowed   = !cfgHalt || oneShotActive;

  // conversion sequencer: remote phase, local phase, then idle until the period ends
  always_comb begin
    next_state         = state;
    next_phaseCnt      = CNT_W'(phaseCnt + 1'b1);
    next_periodCnt     = (periodCnt == {CNT_W{1'b1}}) ? periodCnt : CNT_W'(periodCnt + 1'b1);
    next_oneShotActive = oneShotActive;
    next_remoteSampled = 1'b0;
    next_localSampled  = 1'b0;
    unique case (state)
      ST_HALTED: begin
        next_phaseCnt  = '0;
        next_periodCnt = '0;
        if (!cfgHalt) begin
          next_state = ST_REMOTE;
        end else if (oneShotReq) begin
          next_state         = ST_REMOTE;
          next_oneShotActive = 1'b1;
        end
      end
      ST_REMOTE: begin
        if (!runAllowed) begin
          next_state = ST_HALTED;
        end else if (phaseCnt >= REMOTE_CYCLES - 1'b1) begin
          next_state         = ST_LOCAL;
          next_phaseCnt      = '0;
          next_remoteSampled = 1'b1;
        end
      end
      ST_LOCAL: begin
        if (!runAllowed) begin
          next_state = ST_HALTED;
        end else if (phaseCnt >= localCycles - 1'b1) begin
          next_phaseCnt      = '0;
          next_localSampled  = 1'b1;
          next_oneShotActive = 1'b0;
          next_state         = cfgHalt ? ST_HALTED : ST_IDLE;
        end
      end
      ST_IDLE: begin
        next_phaseCnt = '0;
        if (cfgHalt) begin
          next_state = ST_HALTED;
        end else if (periodCnt >= periodCycles - 1'b1) begin
          next_state     = ST_REMOTE;
          next_periodCnt = '0;
        end
      end
    endcase
    // a fresh conversion restarts the period count from its first cycle
    if (state == ST_HALTED && next_state == ST_REMOTE) begin
      next_periodCnt = '0;
    end
    next_busy            = (next_state == ST_REMOTE) || (next_state == ST_LOCAL);
    next_remoteActive    = (next_state == ST_REMOTE);
    next_localActive     = (next_state == ST_LOCAL);
    next_idealityApplied = (next_state == ST_REMOTE) ? ideality : 8'h00;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state           <= ST_HALTED;
      phaseCnt        <= '0;
      periodCnt       <= '0;
      oneShotActive   <= 1'b0;
      busy            <= 1'b0;
      remoteActive    <= 1'b0;
      localActive     <= 1'b0;
      remoteSampled   <= 1'b0;
      localSampled    <= 1'b0;
      idealityApplied <= 8'h00;
    end else begin
      state           <= next_state;
      phaseCnt        <= next_phaseCnt;
      periodCnt       <= next_periodCnt;
      oneShotActive   <= next_oneShotActive;
      busy            <= next_busy;
      remoteActive    <= next_remoteActive;
      localActive     <= next_localActive;
      remoteSampled   <= next_remoteSampled;
      localSampled    <= next_localSampled;
      idealityApplied <= next_idealityApplied;
    end
  end

  // settings handed to the converter datapath
  assign localPrecision    = {precision[PREC_HI_BIT], precision[PREC_LO_BIT]};
  assign wireResistanceFix = wireFix;

  // per-channel filters; index 0 is local, 1 is remote; comparator results
  // are taken in the cycle the phase ends, so the datapath must have them ready
  assign consecNeed    = tmc_consec_need(consecCode);
  assign chanSample[0] = next_localSampled;
  assign chanSample[1] = next_remoteSampled;
  assign chanOut[0]    = localOutOfLimit;
  assign chanOut[1]    = remoteOutOfLimit;

  generate
    for (genvar ch = 0; ch < 2; ch++) begin : gChan
      tmc_limit_filter uFilter (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .sample     (chanSample[ch]),
        .outOfLimit (chanOut[ch]),
        .need       (consecNeed),
        .trip       (chanTrip[ch])
      );
    end
  endgenerate

  // alarm latch: a trip in the clearing cycle wins so no event is lost;
  // the mask only gates the pin, the latch keeps running underneath
  always_comb begin
    next_alarmState = alarmState;
    if (alarmClear) begin
      next_alarmState = 1'b0;
    end
    if (|chanTrip) begin
      next_alarmState = 1'b1;
    end
    next_alertPinOeN = !(next_alarmState && !next_cfgMask);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      alarmState  <= 1'b0;
      alertPinOeN <= 1'b1;
    end else begin
      alarmState  <= next_alarmState;
      alertPinOeN <= next_alertPinOeN;
    end
  end

  // open drain: the pin only ever pulls low
  assign alertPinOut = 1'b0;

endmodule // tmc_conversion_control

/* File: hdl/tmc_pkg.sv */
// constants, types and helpers shared by the conversion control block
//
// Operation
// - config byte written at pointer 09h, read back at pointer 03h
// - alarm unmasked: pin pulled low after the chosen count of out-of-limit conversions
// - alarm masked: internal alarm state still tracked, pin left released
// - halt clear: conversions run continuously at the selected rate
// - setting halt stops converting at once; clearing it resumes continuous running
// - precision byte read and written at pointer 1Ah, powers up 18h
// - precision bits pick 9/10/11/12 local bits taking 12.5/25/50/100 ms
// - precision leaves remote untouched but changes conversion time and achieved rate
// - wire resistance fix is off after power-on
// - in shutdown a one written to the trigger starts exactly one conversion
// - after a triggered conversion the device goes back to shutdown
// - rate code changes only the idle gap, never the conversion time
// - rate byte read at pointer 04h, powers up 02h, one conversion per four seconds
// - rate codes 0..6 give 0.0625 up to 4 conversions per second, doubling
// - ideality byte at pointer 18h, read and write, two's complement -128..+127
// - ideality byte powers up 00h, the neutral factor, no effect until written
// - ideality correction applies to remote measurements only
// - consecutive out-of-limit count selectable 1..4, default one
package tmc_pkg;

  // register pointers
  localparam logic [7:0] PTR_CONFIG_RD = 8'h03;
  localparam logic [7:0] PTR_RATE_RD   = 8'h04;
  localparam logic [7:0] PTR_CONFIG_WR = 8'h09;
  localparam logic [7:0] PTR_RATE_WR   = 8'h0a;
  localparam logic [7:0] PTR_ONESHOT   = 8'h0f;
  localparam logic [7:0] PTR_IDEALITY  = 8'h18;
  localparam logic [7:0] PTR_PRECISION = 8'h1a;
  localparam logic [7:0] PTR_WIREFIX   = 8'h1b;
  localparam logic [7:0] PTR_CONSEC    = 8'h22;

  // field positions
  localparam int CFG_MASK_BIT    = 7;
  localparam int CFG_HALT_BIT    = 6;
  localparam int PREC_LO_BIT     = 0;
  localparam int PREC_HI_BIT     = 1;
  localparam int ONESHOT_BIT     = 0;
  localparam int WIREFIX_BIT     = 0;
  localparam int CONSEC_LSB      = 0;

  // reset values
  localparam logic [7:0] CONFIG_RST    = 8'h00;
  localparam logic [7:0] RATE_RST      = 8'h02;
  localparam logic [7:0] IDEALITY_RST  = 8'h00;
  localparam logic [7:0] PRECISION_RST = 8'h18;
  localparam logic [7:0] WIREFIX_RST   = 8'h00;
  localparam logic [7:0] CONSEC_RST    = 8'h00;
  localparam logic [7:0] RATE_FASTEST  = 8'h07;

  // timing
  localparam int  CNT_W                = 36;
  localparam real CLK_PERIOD_NS        = 4.0;
  localparam real LOCAL_9BIT_TIME_MS   = 12.5;
  localparam real REMOTE_TIME_MS       = 12.5;
  localparam real SLOWEST_RATE_CPS     = 0.0625;
  localparam logic [CNT_W-1:0] LOCAL_9BIT_CYCLES_DFLT =
    CNT_W'(longint'(LOCAL_9BIT_TIME_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam logic [CNT_W-1:0] REMOTE_CYCLES_DFLT =
    CNT_W'(longint'(REMOTE_TIME_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam logic [CNT_W-1:0] SLOWEST_PERIOD_CYCLES_DFLT =
    CNT_W'(longint'(1.0e9 / (SLOWEST_RATE_CPS * CLK_PERIOD_NS)));

  // register port carriers
  typedef struct packed {
    logic       en;
    logic [7:0] ptr;
    logic [7:0] data;
  } tmc_wr_s;

  typedef struct packed {
    logic       en;
    logic [7:0] ptr;
  } tmc_rd_s;

  typedef enum logic [1:0] {
    ST_HALTED,
    ST_REMOTE,
    ST_LOCAL,
    ST_IDLE
  } tmc_state_e;

  // consecutive code to required count; every code maps to its count of ones plus one
  function automatic logic [2:0] tmc_consec_need(input logic [2:0] code);
    logic [2:0] need;
    need = 3'h1;
    case (code)
      3'h0:    need = 3'h1;
      3'h1:    need = 3'h2;
      3'h3:    need = 3'h3;
      3'h7:    need = 3'h4;
      3'h2,
      3'h4:    need = 3'h2;
      default: need = 3'h3;
    endcase
    return need;
  endfunction

endpackage

/* File: hdl/tmc_limit_filter.sv */
// consecutive out-of-limit counter for one measurement channel
`timescale 1ns/1ps
module tmc_limit_filter (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // measurement result
  input  wire logic       sample,
  input  wire logic       outOfLimit,
  input  wire logic [2:0] need,
  // filtered event
  output logic            trip
);
  import tmc_pkg::*;

  logic [2:0] count;
  logic [2:0] next_count;
  logic [2:0] bumped;

  // saturate at four, the largest count anyone can ask for
  always_comb begin
    bumped     = (count == 3'h4) ? count : 3'(count + 3'h1);
    next_count = count;
    trip       = 1'b0;
    if (sample) begin
      next_count = outOfLimit ? bumped : 3'h0;
      trip       = outOfLimit && (bumped >= need);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count <= 3'h0;
    end else begin
      count <= next_count;
    end
  end

endmodule // tmc_limit_filter

/* File: sim/tmc_host_model.sv */
// host controller model driving the pointer register port
`timescale 1ns/1ps
module tmc_host_model (
  // clock
  input  wire logic       ref_clk,
  // register port
  output tmc_pkg::tmc_wr_s regWr,
  output tmc_pkg::tmc_rd_s regRd,
  input  wire logic [7:0] rdData,
  input  wire logic       rdValid
);
  import tmc_pkg::*;

  // idle port from time zero
  initial begin
    regWr = '0;
    regRd = '0;
  end

  // one byte write; reserved config and precision bits carry their required values
  task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
    logic [7:0] d;
    d = data;
    if (ptr == PTR_CONFIG_WR) d[5:0] = 6'h00;
    if (ptr == PTR_PRECISION) d[7:3] = 5'h03;
    @(negedge ref_clk);
    regWr = '{en: 1'b1, ptr: ptr, data: d};
    @(negedge ref_clk);
    regWr.en = 1'b0;
  endtask

  // one byte read; a missing answer comes back unknown
  // the answer stands one cycle only, so take it at the first falling edge
  task automatic rd(input logic [7:0] ptr, output logic [7:0] data);
    @(negedge ref_clk);
    regRd = '{en: 1'b1, ptr: ptr};
    @(negedge ref_clk);
    data = rdValid ? rdData : 8'hxx;
    regRd.en = 1'b0;
  endtask
endmodule // tmc_host_model

/* File: sim/tmc_conversion_control_asserts.sv */
// port assertions for the conversion control block
`timescale 1ns/1ps
module tmc_conversion_control_asserts #(
  parameter logic [tmc_pkg::CNT_W-1:0] REMOTE_CYCLES         = tmc_pkg::REMOTE_CYCLES_DFLT,
  parameter logic [tmc_pkg::CNT_W-1:0] LOCAL_9BIT_CYCLES     = tmc_pkg::LOCAL_9BIT_CYCLES_DFLT,
  parameter logic [tmc_pkg::CNT_W-1:0] SLOWEST_PERIOD_CYCLES = tmc_pkg::SLOWEST_PERIOD_CYCLES_DFLT
) (
  // clock, reset and register port
  input wire logic       ref_clk,
  input wire logic       rst,
  input tmc_pkg::tmc_wr_s regWr,
  input tmc_pkg::tmc_rd_s regRd,
  input wire logic       rdValid,
  // comparators and outputs
  input wire logic       localOutOfLimit,
  input wire logic       remoteOutOfLimit,
  input wire logic       busy,
  input wire logic       remoteActive,
  input wire logic       localActive,
  input wire logic       remoteSampled,
  input wire logic       localSampled,
  input wire logic [1:0] localPrecision,
  input wire logic [7:0] idealityApplied,
  input wire logic       alertPinOut,
  input wire logic       alertPinOeN,
  input wire logic       alarmState
);
  import tmc_pkg::*;
  logic             cfgWr, osWr, haltReg, maskReg, next_haltReg, next_maskReg;
  logic [CNT_W-1:0] remCnt, locCnt, next_remCnt, next_locCnt;

  // shadow of config bits and phase lengths; aborted phases restart from zero
  always_comb begin
    cfgWr = regWr.en && regWr.ptr == PTR_CONFIG_WR;
    osWr = regWr.en && regWr.ptr == PTR_ONESHOT && regWr.data[ONESHOT_BIT];
    next_haltReg = cfgWr ? regWr.data[CFG_HALT_BIT] : haltReg;
    next_maskReg = cfgWr ? regWr.data[CFG_MASK_BIT] : maskReg;
    next_remCnt = remoteActive ? remCnt + 1'b1 : '0;
    next_locCnt = localActive ? locCnt + 1'b1 : '0;
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {haltReg, maskReg, remCnt, locCnt} <= '0;
    end else begin
      {haltReg, maskReg, remCnt, locCnt} <= {next_haltReg, next_maskReg, next_remCnt, next_locCnt};
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_read_answer: assert property (rdValid == $past(regRd.en)) else $error("read answer late");
  a_mask_release: assert property (maskReg && $past(maskReg) |-> alertPinOeN)
    else $error("masked pin pulled");
  a_pin_shows_alarm: assert property (!maskReg && !$past(maskReg) |->
    alertPinOeN == !alarmState && !alertPinOut) else $error("pin differs from alarm");
  a_alarm_cause: assert property ($rose(alarmState) |->
    (remoteSampled && $past(remoteOutOfLimit)) || (localSampled && $past(localOutOfLimit)))
    else $error("alarm without cause");
  a_remote_length: assert property (remoteSampled |-> remCnt == REMOTE_CYCLES)
    else $error("remote phase length");
  a_local_length: assert property (localSampled |-> locCnt == (LOCAL_9BIT_CYCLES << localPrecision))
    else $error("local phase length");
  a_phase_order: assert property ($fell(remoteActive) && remoteSampled |-> localActive && busy)
    else $error("local phase missing");
  a_ideality_remote: assert property (!remoteActive |-> idealityApplied == 8'h00)
    else $error("ideality outside remote");
  a_halt_stops: assert property ($rose(haltReg) |-> ##[1:2] !busy) else $error("halt ignored");
  a_halt_quiet: assert property ($rose(remoteActive) && haltReg && $past(haltReg, 2) |->
    $past(osWr, 2)) else $error("conversion while halted");
  c_pin_low: cover property ($fell(alertPinOeN));
  c_one_shot: cover property ($rose(remoteActive) && haltReg);
  c_long_local: cover property (localSampled && localPrecision == 2'b11);
endmodule // tmc_conversion_control_asserts

bind tmc_conversion_control tmc_conversion_control_asserts #(.REMOTE_CYCLES(REMOTE_CYCLES),
  .LOCAL_9BIT_CYCLES(LOCAL_9BIT_CYCLES), .SLOWEST_PERIOD_CYCLES(SLOWEST_PERIOD_CYCLES)) chk (.ref_clk, .rst,
  .regWr, .regRd, .rdValid, .localOutOfLimit, .remoteOutOfLimit, .busy, .remoteActive, .localActive,
  .remoteSampled, .localSampled, .localPrecision, .idealityApplied, .alertPinOut, .alertPinOeN, .alarmState);

/* File: sim/testbench.sv */
// self-checking bench for the conversion control block
`timescale 1ns/1ps
module testbench;
  import tmc_pkg::*;
  logic       ref_clk = 1'b0, rst = 1'b1, localOutOfLimit = 1'b0, remoteOutOfLimit = 1'b0, alarmClear = 1'b0;
  tmc_wr_s    regWr;
  tmc_rd_s    regRd;
  logic [7:0] rdData, idealityApplied;
  logic [1:0] localPrecision;
  logic       rdValid, busy, remoteActive, localActive, remoteSampled, localSampled, raDly;
  logic       wireResistanceFix, alertPinOut, alertPinOeN, alarmState;
  int         bad_count = 0, tests_run = 0, cycles = 0;

  // clock and run limit; a hung wait ends here
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      print_verdict();
    end
  end
  always @(negedge ref_clk) raDly <= remoteActive;

  // short counts: 20 cycle phases, 4096 cycle slowest period
  tmc_conversion_control #(.REMOTE_CYCLES(36'h14), .LOCAL_9BIT_CYCLES(36'h14), .SLOWEST_PERIOD_CYCLES(36'h1000)) dut (
    .ref_clk, .rst, .regWr, .regRd, .rdData, .rdValid, .localOutOfLimit, .remoteOutOfLimit, .alarmClear,
    .busy, .remoteActive, .localActive, .remoteSampled, .localSampled, .localPrecision, .idealityApplied,
    .wireResistanceFix, .alertPinOut, .alertPinOeN, .alarmState);
  tmc_host_model host (.ref_clk, .regWr, .regRd, .rdData, .rdValid);

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic rdchk(input logic [7:0] ptr, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(ptr, d);
    chk("read data", {24'h0, exp}, {24'h0, d});
  endtask

  // cycles up to the next start of a remote phase
  task automatic gap(output int n);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (!(remoteActive && !raDly) && n < 9000);
  endtask

  task automatic nextRs;
    do @(negedge ref_clk); while (!remoteSampled);
  endtask

  task automatic pulseClear;
    @(negedge ref_clk);
    alarmClear = 1'b1;
    @(negedge ref_clk);
    alarmClear = 1'b0;
    @(negedge ref_clk);
  endtask

  // phase cycles over a 400 cycle window, longer than any single conversion
  task automatic phases(output int r, output int l, output logic [7:0] id);
    r = 0;
    l = 0;
    id = 8'h00;
    repeat (400) begin
      @(negedge ref_clk);
      r += int'(remoteActive);
      l += int'(localActive);
      if (remoteActive) id = idealityApplied;
    end
  endtask

  task automatic t_reset;
    logic [7:0] ptr [6] = '{8'h03, 8'h04, 8'h18, 8'h1a, 8'h1b, 8'h22};
    logic [7:0] val [6] = '{8'h00, 8'h02, 8'h00, 8'h18, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++) rdchk(ptr[i], val[i]);
    chk("precision", 32'h0, 32'(localPrecision));
    chk("wire fix", 32'h0, 32'(wireResistanceFix));
    $display("t_reset finished");
  endtask

  task automatic t_regs;
    host.wr(PTR_CONFIG_WR, 8'h80);
    rdchk(PTR_CONFIG_RD, 8'h80);
    host.wr(PTR_CONFIG_RD, 8'h40);
    rdchk(PTR_CONFIG_RD, 8'h80);
    rdchk(PTR_CONFIG_WR, 8'h00);
    host.wr(PTR_RATE_WR, 8'h05);
    rdchk(PTR_RATE_RD, 8'h05);
    host.wr(PTR_IDEALITY, 8'h80);
    rdchk(PTR_IDEALITY, 8'h80);
    rdchk(8'h55, 8'h00);
    $display("t_regs finished");
  endtask

  task automatic t_oneshot;
    logic [7:0] idv [4] = '{8'h80, 8'hff, 8'h01, 8'h7f};
    int r, l;
    logic [7:0] id;
    do @(negedge ref_clk); while (!remoteActive);
    host.wr(PTR_CONFIG_WR, 8'h40);
    repeat (2) @(negedge ref_clk);
    chk("busy after halt", 32'h0, 32'(busy));
    phases(r, l, id);
    chk("halted phases", 32'h0, r + l);
    for (int p = 0; p < 4; p++) begin
      host.wr(PTR_PRECISION, 8'h18 | 8'(p));
      rdchk(PTR_PRECISION, 8'h18 | 8'(p));
      chk("precision bits", p, 32'(localPrecision));
      host.wr(PTR_IDEALITY, idv[p]);
      host.wr(PTR_ONESHOT, 8'h01);
      phases(r, l, id);
      chk("remote cycles", 32'd20, r);
      chk("local cycles", 32'd20 << p, l);
      chk("ideality", {24'h0, idv[p]}, {24'h0, id});
    end
    host.wr(PTR_PRECISION, 8'h18);
    $display("t_oneshot finished");
  endtask

  task automatic t_rate;
    int codes [9] = '{0, 1, 2, 3, 4, 5, 6, 7, 9};
    int n, e;
    host.wr(PTR_CONFIG_WR, 8'h00);
    for (int i = 0; i < 9; i++) begin
      host.wr(PTR_RATE_WR, 8'(codes[i]));
      rdchk(PTR_RATE_RD, 8'(codes[i]));
      repeat (3) gap(n);
      e = 4096 >> (codes[i] > 7 ? 7 : codes[i]);
      chk("period", e > 41 ? e : 41, n);
    end
    // precision changed inside a remote phase so no local phase is cut
    gap(n);
    host.wr(PTR_PRECISION, 8'h1b);
    repeat (3) gap(n);
    chk("period 12 bit", 32'd181, n);
    host.wr(PTR_PRECISION, 8'h18);
    $display("t_rate finished");
  endtask

  task automatic t_alarm;
    logic [7:0] codes [4] = '{8'h00, 8'h01, 8'h03, 8'h07};
    int k;
    host.wr(PTR_CONFIG_WR, 8'h80);
    pulseClear();
    remoteOutOfLimit = 1'b1;
    nextRs();
    chk("masked alarm", 32'h1, 32'(alarmState));
    chk("masked pin", 32'h1, 32'(alertPinOeN));
    host.wr(PTR_CONFIG_WR, 8'h00);
    repeat (2) @(negedge ref_clk);
    chk("pin shown", 32'h0, 32'(alertPinOeN));
    for (int i = 0; i < 4; i++) begin
      remoteOutOfLimit = 1'b0;
      nextRs();
      host.wr(PTR_CONSEC, codes[i]);
      pulseClear();
      chk("cleared", 32'h0, 32'(alarmState));
      remoteOutOfLimit = 1'b1;
      k = 0;
      do begin
        nextRs();
        k++;
      end while (!alarmState && k < 8);
      chk("consecutive", i + 1, k);
    end
    // local channel alone must raise the alarm as well
    remoteOutOfLimit = 1'b0;
    host.wr(PTR_CONSEC, 8'h00);
    pulseClear();
    chk("cleared local", 32'h0, 32'(alarmState));
    localOutOfLimit = 1'b1;
    do @(negedge ref_clk); while (!localSampled);
    chk("local alarm", 32'h1, 32'(alarmState));
    chk("local pin", 32'h0, 32'(alertPinOeN));
    localOutOfLimit = 1'b0;
    $display("t_alarm finished");
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // reset, then each scenario in turn
  initial begin
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    t_reset();
    t_regs();
    t_oneshot();
    t_rate();
    t_alarm();
    print_verdict();
  end
endmodule // testbench
